// >>> hdl/gtc_pkg.sv
// Purpose: shared constants and types of the two-channel general timer/counter
// Assumes: 200 MHz sys_clk, classic Wishbone register access with 32-bit data
// Notes: each channel occupies one 32-byte window; interrupt registers sit above both
package gtc_pkg;

  localparam int NUM_CH = 2;
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADR_CH_MASK = 8'he0;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CONFIG = 5'h04;
  localparam logic [4:0] OFS_LOAD1 = 5'h08;
  localparam logic [4:0] OFS_LOAD2 = 5'h0c;
  localparam logic [4:0] OFS_COUNT = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h44;

  ////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_RESET_BIT = 3;

  // configuration field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CLK_EXT_BIT = 4;
  localparam int CFG_GATE_EXT_BIT = 5;
  localparam int CFG_DIR_EXT_BIT = 6;
  localparam int CFG_GATE_LOW_BIT = 8;
  localparam int CFG_DIR_LOW_BIT = 9;
  localparam int CFG_CLKEN_LOW_BIT = 10;
  localparam int CFG_OUT_LOW_BIT = 11;
  localparam int CFG_W = 12;

  // latched status positions
  localparam int ST_ENABLE_BIT = 0;
  localparam int ST_GATE_BIT = 1;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_OUTPUT_BIT = 3;
  localparam int ST_CLOCK_BIT = 4;
  localparam int ST_IRQ_BIT = 5;
  localparam int ST_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CFG_W-1:0] CONFIG_RESET = 12'h000;
  localparam logic [CNT_W-1:0] LOAD_RESET = 16'h0000;
  localparam logic [NUM_CH-1:0] IRQ_MASK_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // internal time base: 50 ns period, i.e. one tick per 10 sys_clk cycles
  localparam int SYS_CLK_MHZ = 200;
  localparam int TIMEBASE_NS = 50;
  localparam int TB_DIV = TIMEBASE_NS * SYS_CLK_MHZ / 1000;
  localparam logic [3:0] TB_LAST = 4'(TB_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // operating modes, encoded 0..7 in the configuration mode field
  typedef enum logic [2:0] {
    gated_event_count_mode,
    period_measure_mode,
    pulse_width_measure_mode,
    gated_single_pulse_mode,
    triggered_single_pulse_mode,
    retriggerable_pulse_mode,
    triggered_continuous_pulse_mode,
    gated_continuous_pulse_mode
  } gtc_mode_t;

  typedef enum logic [2:0] {
    ph_idle,
    ph_measure,
    ph_delay,
    ph_pulse,
    ph_done
  } gtc_phase_t;

endpackage : gtc_pkg

// >>> hdl/gtc_reg_if.sv
// Purpose: register access path between the bus slave and the counter core
// Assumes: wr is a one-cycle pulse per accepted write
// Notes: rdat is combinational from the core, registered by the slave
`timescale 1ns/1ps
`default_nettype none
interface gtc_reg_if;
  logic wr;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [3:0] sel;
  logic [31:0] rdat;

  modport bus (output wr, output adr, output wdat, output sel, input rdat);
  modport core (input wr, input adr, input wdat, input sel, output rdat);
endinterface : gtc_reg_if
`default_nettype wire

// >>> hdl/gtc_wb_slave.sv
// Purpose: classic Wishbone slave front end for the counter registers
// Assumes: master holds cyc/stb and request fields until ack
// Notes: ack one cycle after the request is seen; unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none
module gtc_wb_slave (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  gtc_reg_if.bus regs
);

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gtc_wb_state_t;

  gtc_wb_state_t st_ff;
  gtc_wb_state_t nxt_st;
  logic req;

  ////////////////////////////////////////////////////////////////////////////
  // request is taken once; the held ack blocks a second take
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    regs.wr = req & wb_we_i;
    regs.adr = wb_adr_i;
    regs.wdat = wb_dat_i;
    regs.sel = wb_sel_i;
    nxt_st = st_ff;
    nxt_st.ack = req;
    if (req && !wb_we_i) begin
      nxt_st.dat = regs.rdat;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.dat;

endmodule : gtc_wb_slave
`default_nettype wire

// >>> hdl/gtc_top.sv
// Purpose: two general counter channels with count, measure and pulse modes
// Assumes: pins are asynchronous to sys_clk; external source slower than sys_clk/8
// Notes: channel window at 0x00 and 0x20
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gtc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // counter pins, one bit per channel
  input wire logic [gtc_pkg::NUM_CH-1:0] counter_clock_input_pin,
  input wire logic [gtc_pkg::NUM_CH-1:0] counter_gate_input_pin,
  input wire logic [gtc_pkg::NUM_CH-1:0] counter_direction_input_pin,
  output logic [gtc_pkg::NUM_CH-1:0] counter_output,
  // interrupt
  output logic irq
);

  typedef struct packed {
    gtc_pkg::gtc_phase_t phase;
    logic [gtc_pkg::CNT_W-1:0] count;
    logic [gtc_pkg::CNT_W-1:0] load1;
    logic [gtc_pkg::CNT_W-1:0] load2;
    logic [gtc_pkg::CFG_W-1:0] cfg;
    logic soft_gate;
    logic soft_dir;
    logic soft_run;
    logic pulse_on;
    logic out_pin;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pin_ok;
    logic src_prev;
    logic gate_prev;
    logic [gtc_pkg::ST_W-1:0] status;
  } gtc_chan_t;

  typedef struct packed {
    gtc_chan_t [gtc_pkg::NUM_CH-1:0] chan;
    logic [3:0] tb_cnt;
    logic tb_tick;
    logic [gtc_pkg::NUM_CH-1:0] irq_status;
    logic [gtc_pkg::NUM_CH-1:0] irq_mask;
    logic irq;
  } gtc_state_t;

  gtc_state_t st_ff;
  gtc_state_t nxt_st;
  gtc_reg_if regs ();
  logic [31:0] ch_word [gtc_pkg::NUM_CH];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-enable merge for a writable word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wdat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic chan_hit(input logic [7:0] adr, input int c);
    return (adr & gtc_pkg::ADR_CH_MASK) == 8'(c * 32);
  endfunction : chan_hit

  // read-only view; a read has no side effect on the channel
  function automatic logic [31:0] chan_read(input gtc_chan_t ch, input logic [4:0] ofs);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (ofs)
      gtc_pkg::OFS_CTRL: begin
        w[gtc_pkg::CTRL_GATE_BIT] = ch.soft_gate;
        w[gtc_pkg::CTRL_DIR_BIT] = ch.soft_dir;
        w[gtc_pkg::CTRL_RUN_BIT] = ch.soft_run;
      end
      gtc_pkg::OFS_CONFIG: w[gtc_pkg::CFG_W-1:0] = ch.cfg;
      gtc_pkg::OFS_LOAD1: w[gtc_pkg::CNT_W-1:0] = ch.load1;
      gtc_pkg::OFS_LOAD2: w[gtc_pkg::CNT_W-1:0] = ch.load2;
      gtc_pkg::OFS_COUNT: w[gtc_pkg::CNT_W-1:0] = ch.count;
      gtc_pkg::OFS_STATUS: w[gtc_pkg::ST_W-1:0] = ch.status;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : chan_read

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  gtc_wb_slave u_wb_slave (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .regs(regs)
  );

  for (genvar gc = 0; gc < gtc_pkg::NUM_CH; gc++) begin : g_rd
    assign ch_word[gc] = chan_hit(regs.adr, gc) ? chan_read(st_ff.chan[gc], regs.adr[4:0]) : 32'h0000_0000;
  end

  always_comb begin
    regs.rdat = ch_word[0] | ch_word[1];
    if (regs.adr == gtc_pkg::ADR_IRQ_STATUS) begin
      regs.rdat = {30'h0000_0000, st_ff.irq_status};
    end else if (regs.adr == gtc_pkg::ADR_IRQ_MASK) begin
      regs.rdat = {30'h0000_0000, st_ff.irq_mask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0] mw;
    logic src_lvl;
    logic tick;
    logic gate_act;
    logic dir_up;
    logic gate_rise;
    logic gate_fall;
    logic terminal;
    logic start;
    logic hold;
    logic wr_ctrl;
    gtc_pkg::gtc_mode_t mode;
    mw = 32'h0000_0000;
    src_lvl = 1'b0;
    tick = 1'b0;
    gate_act = 1'b0;
    dir_up = 1'b0;
    gate_rise = 1'b0;
    gate_fall = 1'b0;
    terminal = 1'b0;
    start = 1'b0;
    hold = 1'b0;
    wr_ctrl = 1'b0;
    mode = gtc_pkg::gated_event_count_mode;
    nxt_st = st_ff;

    // shared internal time base
    nxt_st.tb_tick = (st_ff.tb_cnt == gtc_pkg::TB_LAST);
    nxt_st.tb_cnt = nxt_st.tb_tick ? 4'h0 : st_ff.tb_cnt + 4'h1;

    for (int c = 0; c < gtc_pkg::NUM_CH; c++) begin
      // three-stage pin capture; a level is taken once stages two and three agree
      nxt_st.chan[c].sync1 = {counter_direction_input_pin[c], counter_gate_input_pin[c],
                              counter_clock_input_pin[c]};
      nxt_st.chan[c].sync2 = st_ff.chan[c].sync1;
      nxt_st.chan[c].sync3 = st_ff.chan[c].sync2;
      nxt_st.chan[c].pin_ok = (~(st_ff.chan[c].sync2 ^ st_ff.chan[c].sync3) & st_ff.chan[c].sync3)
                            | ((st_ff.chan[c].sync2 ^ st_ff.chan[c].sync3) & st_ff.chan[c].pin_ok);

      src_lvl = st_ff.chan[c].pin_ok[0] ^ st_ff.chan[c].cfg[gtc_pkg::CFG_CLKEN_LOW_BIT];
      nxt_st.chan[c].src_prev = src_lvl;
      tick = st_ff.chan[c].cfg[gtc_pkg::CFG_CLK_EXT_BIT] ? (src_lvl & ~st_ff.chan[c].src_prev)
                                                         : st_ff.tb_tick;
      gate_act = (st_ff.chan[c].cfg[gtc_pkg::CFG_GATE_EXT_BIT] ? st_ff.chan[c].pin_ok[1]
                                                               : st_ff.chan[c].soft_gate)
               ^ st_ff.chan[c].cfg[gtc_pkg::CFG_GATE_LOW_BIT];
      dir_up = (st_ff.chan[c].cfg[gtc_pkg::CFG_DIR_EXT_BIT] ? st_ff.chan[c].pin_ok[2]
                                                            : st_ff.chan[c].soft_dir)
             ^ st_ff.chan[c].cfg[gtc_pkg::CFG_DIR_LOW_BIT];
      gate_rise = gate_act & ~st_ff.chan[c].gate_prev;
      gate_fall = ~gate_act & st_ff.chan[c].gate_prev;
      nxt_st.chan[c].gate_prev = gate_act;
      mode = gtc_pkg::gtc_mode_t'(st_ff.chan[c].cfg[gtc_pkg::CFG_MODE_LSB +: 3]);
      terminal = 1'b0;
      start = 1'b0;
      hold = 1'b0;

      if (st_ff.chan[c].soft_run) begin
        case (mode)
          gtc_pkg::gated_event_count_mode: begin
            if (gate_act && tick) begin
              terminal = dir_up ? (st_ff.chan[c].count == 16'hffff) : (st_ff.chan[c].count == 16'h0000);
              nxt_st.chan[c].count = dir_up ? st_ff.chan[c].count + 16'h0001
                                            : st_ff.chan[c].count - 16'h0001;
            end
          end
          gtc_pkg::period_measure_mode,
          gtc_pkg::pulse_width_measure_mode: begin
            case (st_ff.chan[c].phase)
              gtc_pkg::ph_idle: begin
                // measurement starts at the first load value
                if (gate_rise) begin
                  nxt_st.chan[c].phase = gtc_pkg::ph_measure;
                  nxt_st.chan[c].count = st_ff.chan[c].load1;
                end
              end
              gtc_pkg::ph_measure: begin
                if (mode == gtc_pkg::period_measure_mode ? gate_rise : gate_fall) begin
                  nxt_st.chan[c].phase = gtc_pkg::ph_done;
                  terminal = 1'b1;
                end else if (tick) begin
                  nxt_st.chan[c].count = dir_up ? st_ff.chan[c].count + 16'h0001
                                                : st_ff.chan[c].count - 16'h0001;
                end
              end
              default: begin
                nxt_st.chan[c].phase = gtc_pkg::ph_done;
              end
            endcase
          end
          default: begin
            // pulse generators share one delay/width engine
            case (mode)
              gtc_pkg::gated_single_pulse_mode,
              gtc_pkg::gated_continuous_pulse_mode: begin
                start = gate_act && st_ff.chan[c].phase == gtc_pkg::ph_idle;
                hold = ~gate_act;
              end
              gtc_pkg::retriggerable_pulse_mode: begin
                start = gate_rise;
              end
              default: begin
                start = gate_rise && st_ff.chan[c].phase == gtc_pkg::ph_idle;
              end
            endcase
            if (start) begin
              // delay from the first load value
              nxt_st.chan[c].phase = gtc_pkg::ph_delay;
              nxt_st.chan[c].count = st_ff.chan[c].load1;
              nxt_st.chan[c].pulse_on = 1'b0;
            end else if (tick && !hold) begin
              case (st_ff.chan[c].phase)
                gtc_pkg::ph_delay: begin
                  if (st_ff.chan[c].count <= 16'h0001) begin
                    // width from the second load value
                    nxt_st.chan[c].phase = gtc_pkg::ph_pulse;
                    nxt_st.chan[c].count = st_ff.chan[c].load2;
                    nxt_st.chan[c].pulse_on = 1'b1;
                  end else begin
                    nxt_st.chan[c].count = st_ff.chan[c].count - 16'h0001;
                  end
                end
                gtc_pkg::ph_pulse: begin
                  if (st_ff.chan[c].count <= 16'h0001) begin
                    terminal = 1'b1;
                    nxt_st.chan[c].pulse_on = 1'b0;
                    nxt_st.chan[c].count = st_ff.chan[c].load1;
                    case (mode)
                      gtc_pkg::triggered_continuous_pulse_mode,
                      gtc_pkg::gated_continuous_pulse_mode: nxt_st.chan[c].phase = gtc_pkg::ph_delay;
                      gtc_pkg::retriggerable_pulse_mode: nxt_st.chan[c].phase = gtc_pkg::ph_idle;
                      default: nxt_st.chan[c].phase = gtc_pkg::ph_done;
                    endcase
                  end else begin
                    nxt_st.chan[c].count = st_ff.chan[c].count - 16'h0001;
                  end
                end
                default: begin
                  nxt_st.chan[c].phase = st_ff.chan[c].phase;
                end
              endcase
            end
          end
        endcase
      end

      // register writes of this channel
      wr_ctrl = 1'b0;
      if (regs.wr && chan_hit(regs.adr, c)) begin
        case (regs.adr[4:0])
          gtc_pkg::OFS_CTRL: begin
            // software controls in the low byte
            if (regs.sel[0]) begin
              wr_ctrl = regs.wdat[gtc_pkg::CTRL_RESET_BIT];
              nxt_st.chan[c].soft_gate = regs.wdat[gtc_pkg::CTRL_GATE_BIT];
              nxt_st.chan[c].soft_dir = regs.wdat[gtc_pkg::CTRL_DIR_BIT];
              nxt_st.chan[c].soft_run = regs.wdat[gtc_pkg::CTRL_RUN_BIT];
            end
          end
          gtc_pkg::OFS_CONFIG: begin
            mw = merge_bytes({20'h00000, st_ff.chan[c].cfg}, regs.wdat, regs.sel);
            nxt_st.chan[c].cfg = mw[gtc_pkg::CFG_W-1:0];
          end
          gtc_pkg::OFS_LOAD1: begin
            mw = merge_bytes({16'h0000, st_ff.chan[c].load1}, regs.wdat, regs.sel);
            nxt_st.chan[c].load1 = mw[gtc_pkg::CNT_W-1:0];
          end
          gtc_pkg::OFS_LOAD2: begin
            mw = merge_bytes({16'h0000, st_ff.chan[c].load2}, regs.wdat, regs.sel);
            nxt_st.chan[c].load2 = mw[gtc_pkg::CNT_W-1:0];
          end
          default: begin
            wr_ctrl = 1'b0;
          end
        endcase
      end

      if (wr_ctrl) begin
        nxt_st.chan[c].soft_run = 1'b0;
        nxt_st.chan[c].count = st_ff.chan[c].load1;
        nxt_st.chan[c].phase = gtc_pkg::ph_idle;
        nxt_st.chan[c].pulse_on = 1'b0;
      end

      nxt_st.chan[c].out_pin = nxt_st.chan[c].pulse_on ^ st_ff.chan[c].cfg[gtc_pkg::CFG_OUT_LOW_BIT];

      // set wins over a write-one clear in the same cycle
      nxt_st.irq_status[c] = terminal | (st_ff.irq_status[c]
        & ~(regs.wr && regs.adr == gtc_pkg::ADR_IRQ_STATUS && regs.sel[0] && regs.wdat[c]));

      // latched snapshot, one cycle behind the live state
      nxt_st.chan[c].status[gtc_pkg::ST_ENABLE_BIT] = st_ff.chan[c].soft_run;
      nxt_st.chan[c].status[gtc_pkg::ST_GATE_BIT] = gate_act;
      nxt_st.chan[c].status[gtc_pkg::ST_DIR_BIT] = dir_up;
      nxt_st.chan[c].status[gtc_pkg::ST_OUTPUT_BIT] = st_ff.chan[c].out_pin;
      nxt_st.chan[c].status[gtc_pkg::ST_CLOCK_BIT] = st_ff.chan[c].cfg[gtc_pkg::CFG_CLK_EXT_BIT] ? src_lvl
                                                                                               : st_ff.tb_tick;
      nxt_st.chan[c].status[gtc_pkg::ST_IRQ_BIT] = st_ff.irq_status[c];
    end

    if (regs.wr && regs.adr == gtc_pkg::ADR_IRQ_MASK && regs.sel[0]) begin
      nxt_st.irq_mask = regs.wdat[gtc_pkg::NUM_CH-1:0];
    end
    nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      for (int c = 0; c < gtc_pkg::NUM_CH; c++) begin
        st_ff.chan[c].cfg <= gtc_pkg::CONFIG_RESET;
        st_ff.chan[c].load1 <= gtc_pkg::LOAD_RESET;
        st_ff.chan[c].load2 <= gtc_pkg::LOAD_RESET;
        st_ff.chan[c].phase <= gtc_pkg::ph_idle;
      end
      st_ff.irq_mask <= gtc_pkg::IRQ_MASK_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  for (genvar gc = 0; gc < gtc_pkg::NUM_CH; gc++) begin : g_out
    assign counter_output[gc] = st_ff.chan[gc].out_pin;
  end
  assign irq = st_ff.irq;

endmodule : gtc_top
`default_nettype wire

// >>> verification/gtc_chk.sv
// Purpose: port checks of the counter block
// Assumes: master holds each request until ack
// Notes: read answers checked for field widths
`timescale 1ns/1ps
`default_nettype none
module gtc_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // outputs
  input wire logic [1:0] counter_output,
  input wire logic irq
);
  logic rd;
  logic [4:0] ofs;
  assign rd = wb_ack_o && !wb_we_i && wb_adr_i < 8'h40;
  assign ofs = wb_adr_i[4:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  ack_in_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  count_width_a: assert property (rd && ofs == 5'h10 |-> wb_dat_o[31:16] == 16'h0) else $error("count wide");
  cmd_reads_zero_a: assert property (rd && ofs == 5'h00 |-> wb_dat_o[31:3] == 29'h0) else $error("ctrl bits");
  cfg_width_a: assert property (rd && ofs == 5'h04 |-> wb_dat_o[31:12] == 20'h0) else $error("config wide");
  load_width_a: assert property (rd && ofs[4:3] == 2'h1 |-> wb_dat_o[31:16] == 16'h0) else $error("load wide");
  status_width_a: assert property (rd && ofs == 5'h14 |-> wb_dat_o[31:6] == 26'h0) else $error("status wide");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h44 |-> wb_dat_o == 32'h0)
    else $error("unmapped data");
  mask_off_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h44 && wb_dat_i[1:0] == 2'h0
    |-> ##[0:2] !irq) else $error("irq not masked");
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(irq));
  cover property ($rose(counter_output[1]));
endmodule : gtc_chk
bind gtc_top gtc_chk u_chk (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .counter_output, .irq);
`default_nettype wire

// >>> verification/gtc_pins.sv
// Purpose: far side pins: count source, gate, direction
// Assumes: levels change just after a rising edge
// Notes: source levels held four cycles, above the filter
`timescale 1ns/1ps
`default_nettype none
module gtc_pins (
  // clock
  input wire logic sys_clk,
  // pins
  output logic [1:0] cp,
  output logic [1:0] gp,
  output logic [1:0] dp
);
  initial begin
    cp = 2'h0;
    gp = 2'h0;
    dp = 2'h0;
  end
  task automatic pulse(input int ch, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge sys_clk);
      cp[ch] <= ~cp[ch];
      repeat (3) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask : pulse
  task automatic set(input int ch, input logic g, input logic d);
    @(posedge sys_clk);
    gp[ch] <= g;
    dp[ch] <= d;
    repeat (7) @(posedge sys_clk);
  endtask : set
endmodule : gtc_pins
`default_nettype wire

// >>> verification/gtc_top_test.sv
// Purpose: register and pin tests of the counter block
// Assumes: one-cycle ack, pins seen a few cycles late
// Notes: pin source used so counts are exact
`timescale 1ns/1ps
`default_nettype none
module gtc_top_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o, rd_val;
  logic wb_ack_o, irq;
  logic [1:0] counter_clock_input_pin, counter_gate_input_pin, counter_direction_input_pin, counter_output;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  initial forever #2.5 sys_clk = ~sys_clk;
  gtc_top u_dut (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .counter_clock_input_pin, .counter_gate_input_pin, .counter_direction_input_pin,
    .counter_output, .irq);
  gtc_pins u_pins (.sys_clk, .cp(counter_clock_input_pin), .gp(counter_gate_input_pin),
    .dp(counter_direction_input_pin));
  ////////////////////////////////////////
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd_val = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 32'h0, 1'b0);
    check(rd_val, exp);
  endtask : rdchk
  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // a hung handshake ends here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdchk(8'h04, 32'h0);
    rdchk(8'h44, 32'h0);
    wb(8'h08, 32'h1234);
    wb(8'h28, 32'habcd);
    rdchk(8'h08, 32'h1234);
    rdchk(8'h28, 32'habcd);
    rdchk(8'h80, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wb(8'h24, 32'(m));
      rdchk(8'h24, 32'(m));
    end
    wb(8'h04, 32'h10);
    wb(8'h00, 32'h8);
    rdchk(8'h10, 32'h1234);
    wb(8'h00, 32'h7);
    u_pins.pulse(0, 3);
    rdchk(8'h10, 32'h1237);
    rdchk(8'h10, 32'h1237);
    wb(8'h00, 32'h8);
    u_pins.pulse(0, 2);
    rdchk(8'h10, 32'h1234);
    wb(8'h00, 32'h5);
    u_pins.pulse(0, 4);
    rdchk(8'h10, 32'h1230);
    wb(8'h00, 32'h3);
    u_pins.pulse(0, 2);
    rdchk(8'h10, 32'h1230);
    // gate and direction from pins, gate low-active
    wb(8'h04, 32'h170);
    wb(8'h00, 32'h4);
    u_pins.set(0, 1'b1, 1'b1);
    u_pins.pulse(0, 2);
    rdchk(8'h10, 32'h1230);
    u_pins.set(0, 1'b0, 1'b0);
    u_pins.pulse(0, 2);
    rdchk(8'h10, 32'h122e);
    // down through zero raises the event
    wb(8'h08, 32'h1);
    wb(8'h04, 32'h10);
    wb(8'h00, 32'h8);
    wb(8'h00, 32'h5);
    u_pins.pulse(0, 2);
    rdchk(8'h10, 32'hffff);
    rdchk(8'h40, 32'h1);
    wb(8'h44, 32'h0);
    @(posedge sys_clk);
    check(32'(irq), 32'h0);
    wb(8'h44, 32'h1);
    @(posedge sys_clk);
    check(32'(irq), 32'h1);
    wb(8'h40, 32'h1);
    @(posedge sys_clk);
    check(32'(irq), 32'h0);
    // triggered single pulse: delay two ticks, width three
    wb(8'h28, 32'h2);
    wb(8'h2c, 32'h3);
    wb(8'h24, 32'h34);
    wb(8'h20, 32'h4);
    u_pins.set(1, 1'b1, 1'b0);
    u_pins.pulse(1, 1);
    check(32'(counter_output[1]), 32'h0);
    u_pins.pulse(1, 1);
    check(32'(counter_output[1]), 32'h1);
    u_pins.pulse(1, 2);
    check(32'(counter_output[1]), 32'h1);
    u_pins.pulse(1, 1);
    check(32'(counter_output[1]), 32'h0);
    rdchk(8'h40, 32'h2);
    wb(8'h24, 32'h834);
    @(posedge sys_clk);
    check(32'(counter_output[1]), 32'h1);
    check(32'(counter_output), 32'h2);
    // enable, gate, output and interrupt set; clock pin low
    rdchk(8'h34, 32'h2b);
    // internal time base: run spans exactly 100 cycles, so 10 ticks whatever the phase
    wb(8'h04, 32'h0);
    wb(8'h08, 32'h0);
    wb(8'h00, 32'h8);
    wb(8'h00, 32'h7);
    repeat (97) @(posedge sys_clk);
    wb(8'h00, 32'h3);
    rdchk(8'h10, 32'ha);
    // period measure from the gate pin, starting at the first load value
    wb(8'h08, 32'h100);
    wb(8'h04, 32'h31);
    wb(8'h00, 32'ha);
    wb(8'h00, 32'h6);
    u_pins.set(0, 1'b1, 1'b0);
    u_pins.pulse(0, 3);
    u_pins.set(0, 1'b0, 1'b0);
    u_pins.pulse(0, 2);
    u_pins.set(0, 1'b1, 1'b0);
    u_pins.pulse(0, 1);
    rdchk(8'h10, 32'h105);
    rdchk(8'h40, 32'h3);
    test_done();
  end
endmodule : gtc_top_test
`default_nettype wire
